/* File: inc/dwsl_pkg.sv */
// constants shared by the dual wiper serial loader
// assumes a host that shifts frames of select bit plus eight code bits, msb first
package dwsl_pkg;
	localparam int          WIPER_W       = 8;        // wiper code width
	localparam int          TAP_COUNT     = 256;      // taps per resistor string
	localparam int          FRAME_BITS    = 9;        // bits kept as one frame
	localparam int          SEL_POS       = 8;        // select bit in the shift register
	localparam int          CODE_MSB      = 7;        // top code bit in the shift register
	localparam logic        SEL_A         = 1'h0;     // select value for wiper a
	localparam logic        SEL_B         = 1'h1;     // select value for wiper b
	localparam logic [7:0]  RESET_CODE    = 8'h80;    // midscale after reset
	localparam int          CNT_W         = 8;        // width of the edge counter
	localparam int          SYNC_STAGES   = 3;        // flops on a crossing input
	localparam int          SETTLE_CYCLES = 2;        // wait after chip select rise

	// binary to gray for the crossing edge counter
	function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	// gray back to binary on the receiving side
	function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
		logic [CNT_W-1:0] b;
		b = '0;
		for (int i = CNT_W - 1; i >= 0; i--) begin
			b[i] = g[i] ^ ((i == CNT_W - 1) ? 1'b0 : b[i+1]);
		end
		return b;
	endfunction
endpackage

/* File: hw/dwsl_sync.sv */
// three-flop synchroniser with agreement filter
// assumes the input comes from another clock or a pin; vector inputs must be gray coded
module dwsl_sync
	import dwsl_pkg::*;
#(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// crossing level
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire          agree = (s2 == s3);

	// chain of three; only the second flop reads the first
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1 <= RST;
			s2 <= RST;
			s3 <= RST;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a change counts once second and third agree
	always_ff @(posedge clk) begin
		if (!rstn) begin
			q <= RST;
		end else if (agree) begin
			q <= s3;
		end
	end
endmodule

/* File: hw/dwsl_top.sv */
// dual wiper serial loader: write-only three-wire receiver and two wiper registers
// assumes sclk is the host clock, idle between frames, and csN/din change around it
module dwsl_top
	import dwsl_pkg::*;
#(
	parameter int TAPS = TAP_COUNT
) (
	// system clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// serial link from the host
	input  wire logic              sclk,
	input  wire logic              csN,
	input  wire logic              din,
	// wiper codes
	output logic     [WIPER_W-1:0] wiperPositionA,
	output logic     [WIPER_W-1:0] wiperPositionB,
	// one-hot tap selects for the strings
	output logic     [TAPS-1:0]    tapSelectA,
	output logic     [TAPS-1:0]    tapSelectB,
	// frame outcome pulses
	output logic                   commitDone,
	output logic                   frameDropped
);
	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_SETTLE} dwsl_state_t;

	// one-hot tap decode of a wiper code
	function automatic logic [TAPS-1:0] tapDecode(input logic [WIPER_W-1:0] code);
		logic [TAPS-1:0] t;
		t = '0;
		t[code] = 1'b1;
		return t;
	endfunction

	// ---------------- link domain ----------------
	logic [1:0]          linkRstSync;
	logic                linkRstn;
	logic [SEL_POS:0]    shiftReg;
	logic [CNT_W-1:0]    edgeCnt;
	logic [CNT_W-1:0]    edgeGray;
	wire  [CNT_W-1:0]    next_edgeCnt = edgeCnt + 1'b1;

	// reset carried into the link clock
	always_ff @(posedge sclk) begin
		linkRstSync <= {linkRstSync[0], rstn};
	end
	assign linkRstn = linkRstSync[1];

	// input-only shifter, no data ever leaves the device
	always_ff @(posedge sclk) begin
		if (!linkRstn) begin
			shiftReg <= '0;
			edgeCnt  <= '0;
			edgeGray <= '0;
		end else if (!csN) begin
			shiftReg <= {shiftReg[SEL_POS-1:0], din};
			edgeCnt  <= next_edgeCnt;
			edgeGray <= bin2gray(next_edgeCnt);
		end
	end

	// ---------------- system domain ----------------
	logic                csHigh;
	logic                csPrev;
	logic [CNT_W-1:0]    graySync;
	logic [CNT_W-1:0]    startCnt;
	logic                reachedNine;
	logic [1:0]          settleCnt;
	dwsl_state_t         state;
	dwsl_state_t         next_state;
	logic [WIPER_W-1:0]  next_wiperA;
	logic [WIPER_W-1:0]  next_wiperB;

	// chip select and edge count cross into mclk
	dwsl_sync #(.W(1), .RST(1'h1)) uCsSync (
		.clk  (mclk),
		.rstn (rstn),
		.d    (csN),
		.q    (csHigh)
	);
	dwsl_sync #(.W(CNT_W), .RST('0)) uCntSync (
		.clk  (mclk),
		.rstn (rstn),
		.d    (edgeGray),
		.q    (graySync)
	);

	// frame edges and running edge count
	wire                csFall   = csPrev & ~csHigh;
	wire                csRise   = ~csPrev & csHigh;
	wire  [CNT_W-1:0]   frameCnt = gray2bin(graySync) - startCnt;
	wire                enough   = (frameCnt >= CNT_W'(FRAME_BITS));
	wire                settled  = (state == ST_SETTLE) && (settleCnt == 2'(SETTLE_CYCLES - 1));

	// shift register is still while select is high, so it is read as a quiet word
	wire                frameOk   = settled && (reachedNine || enough);
	wire                frameBad  = settled && !(reachedNine || enough);
	wire                selBit    = shiftReg[SEL_POS];
	wire  [WIPER_W-1:0] frameCode = shiftReg[CODE_MSB:0];
	wire                commitA   = frameOk && (selBit == SEL_A);
	wire                commitB   = frameOk && (selBit == SEL_B);

	// next wiper codes; the unaddressed one holds
	assign next_wiperA = commitA ? frameCode : wiperPositionA;
	assign next_wiperB = commitB ? frameCode : wiperPositionB;

	// frame sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (csFall) begin
					next_state = ST_FRAME;
				end
			end
			ST_FRAME: begin
				if (csRise) begin
					next_state = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (settled) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// state, select history and settle count
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state     <= ST_IDLE;
			csPrev    <= 1'h1;
			settleCnt <= '0;
		end else begin
			state     <= next_state;
			csPrev    <= csHigh;
			settleCnt <= (state == ST_SETTLE) ? settleCnt + 1'b1 : 2'h0;
		end
	end

	// edge count base and nine-edge mark, sampled often enough to see wraps
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			startCnt    <= '0;
			reachedNine <= 1'h0;
		end else if (state == ST_IDLE && csFall) begin
			startCnt    <= gray2bin(graySync);
			reachedNine <= 1'h0;
		end else if (state != ST_IDLE && enough) begin
			reachedNine <= 1'h1;
		end
	end

	// wiper registers and tap selects update together
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wiperPositionA <= RESET_CODE;
			wiperPositionB <= RESET_CODE;
			tapSelectA     <= tapDecode(RESET_CODE);
			tapSelectB     <= tapDecode(RESET_CODE);
		end else begin
			wiperPositionA <= next_wiperA;
			wiperPositionB <= next_wiperB;
			tapSelectA     <= tapDecode(next_wiperA);
			tapSelectB     <= tapDecode(next_wiperB);
		end
	end

	// outcome pulses
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			commitDone   <= 1'h0;
			frameDropped <= 1'h0;
		end else begin
			commitDone   <= frameOk;
			frameDropped <= frameBad;
		end
	end

	// ---------------- checks ----------------
	property p_reset_mid;
		@(posedge mclk) disable iff (!rstn)
		$rose(rstn) |-> (wiperPositionA == 8'h80) && (wiperPositionB == 8'h80);
	endproperty
	a_reset_mid: assert property (p_reset_mid) else $error("wiper not midscale after reset");

	property p_shift_in;
		@(posedge sclk) disable iff (!linkRstn)
		!csN |=> shiftReg[0] == $past(din) && shiftReg[SEL_POS:1] == $past(shiftReg[SEL_POS-1:0]);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("din not shifted on sclk");

	property p_idle_hold;
		@(posedge sclk) disable iff (!linkRstn)
		csN |=> $stable(shiftReg) && $stable(edgeCnt);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("shift while deselected");

	property p_load_a;
		@(posedge mclk) disable iff (!rstn)
		frameOk && !selBit |=> wiperPositionA == $past(frameCode) && commitDone && $stable(wiperPositionB);
	endproperty
	a_load_a: assert property (p_load_a) else $error("frame not loaded into wiper a");

	property p_load_b;
		@(posedge mclk) disable iff (!rstn)
		frameOk && selBit |=> wiperPositionB == $past(frameCode) && $stable(wiperPositionA);
	endproperty
	a_load_b: assert property (p_load_b) else $error("frame b wrong or a disturbed");

	property p_change_cause;
		@(posedge mclk) disable iff (!rstn)
		!$stable(wiperPositionA) || !$stable(wiperPositionB) |-> commitDone && csHigh;
	endproperty
	a_change_cause: assert property (p_change_cause) else $error("wiper moved without commit");

	property p_short_drop;
		@(posedge mclk) disable iff (!rstn)
		frameBad |=> $stable(wiperPositionA) && $stable(wiperPositionB) && frameDropped;
	endproperty
	a_short_drop: assert property (p_short_drop) else $error("short frame changed a wiper");

	property p_rise_outcome;
		@(posedge mclk) disable iff (!rstn)
		state == ST_FRAME && csRise |-> ##3 (commitDone || frameDropped) ##0 state == ST_IDLE;
	endproperty
	a_rise_outcome: assert property (p_rise_outcome) else $error("no outcome after select rise");

	property p_tap_match;
		@(posedge mclk) disable iff (!rstn)
		1'b1 |-> $onehot(tapSelectA) && $onehot(tapSelectB) && tapSelectA[wiperPositionA] && tapSelectB[wiperPositionB];
	endproperty
	a_tap_match: assert property (p_tap_match) else $error("tap select disagrees with code");

	property p_count_nine;
		@(posedge mclk) disable iff (!rstn)
		frameOk |-> reachedNine || (edgeCnt - startCnt) >= 8'h09;
	endproperty
	a_count_nine: assert property (p_count_nine) else $error("commit with fewer than nine edges");

	// link count checks
	property p_edge_step;
		@(posedge sclk) disable iff (!linkRstn)
		!csN |=> edgeCnt == $past(edgeCnt) + 8'h01 && edgeGray == bin2gray(edgeCnt);
	endproperty
	a_edge_step: assert property (p_edge_step) else $error("edge count did not step on sclk");

	property p_count_settled;
		@(posedge mclk) disable iff (!rstn)
		state == ST_SETTLE |-> graySync == edgeGray;
	endproperty
	a_count_settled: assert property (p_count_settled) else $error("edge count not settled at commit");

	// frame sequencing checks
	property p_frame_start;
		@(posedge mclk) disable iff (!rstn)
		state == ST_IDLE && csFall |=> state == ST_FRAME && !reachedNine;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame start not taken");

	property p_frame_quiet;
		@(posedge mclk) disable iff (!rstn)
		state == ST_FRAME |=> $stable(wiperPositionA) && $stable(wiperPositionB);
	endproperty
	a_frame_quiet: assert property (p_frame_quiet) else $error("wiper moved inside a frame");

	property p_settle_len;
		@(posedge mclk) disable iff (!rstn)
		state == ST_FRAME && csRise |=> state == ST_SETTLE ##1 state == ST_SETTLE ##1 state == ST_IDLE;
	endproperty
	a_settle_len: assert property (p_settle_len) else $error("settle window length wrong");

	property p_pulse_single;
		@(posedge mclk) disable iff (!rstn)
		commitDone || frameDropped |-> !(commitDone && frameDropped) ##1 !commitDone && !frameDropped;
	endproperty
	a_pulse_single: assert property (p_pulse_single) else $error("outcome pulse too long or doubled");

	// scenario covers
	c_commit_a: cover property (@(posedge mclk) disable iff (!rstn) frameOk && !selBit);
	c_commit_b: cover property (@(posedge mclk) disable iff (!rstn) frameOk && selBit);
	c_dropped:  cover property (@(posedge mclk) disable iff (!rstn) frameBad);
	c_long:     cover property (@(posedge mclk) disable iff (!rstn) frameOk && frameCnt > 8'h09);
	c_idle_clock: cover property (@(posedge sclk) disable iff (!linkRstn) csN);
endmodule

/* File: tb/dwsl_host.sv */
// host model: drives write frames on the three-wire link
// assumes a 6 ns serial clock that stands low outside frames and pulse bursts
module dwsl_host (
	// serial link to the device
	output logic sclk,
	output logic csN,
	output logic din
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle link: chip select high, clock low
	initial begin
		sclk = 1'b0;
		csN  = 1'b1;
		din  = 1'b0;
	end

	// clock edges with chip select high, data wiggling
	task automatic pulse(input int n);
		repeat (n) begin
			din = ~din;
			#3 sclk = 1'b1;
			#3 sclk = 1'b0;
		end
	endtask

	// one frame, msb first, chip select held low throughout
	task automatic send(input logic [15:0] bits, input int n);
		csN = 1'b0;
		#42;
		for (int i = n - 1; i >= 0; i--) begin
			din = bits[i];
			#3 sclk = 1'b1;
			#3 sclk = 1'b0;
		end
		#6 csN = 1'b1;
		din = ~din; // released line shows no stale value
	endtask
endmodule

/* File: tb/dwsl_top_test.sv */
// self-checking bench for the dual wiper serial loader
// assumes the host model in dwsl_host and the design top dwsl_top
module dwsl_top_test
	import dwsl_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic               mclk = 1'b0;
	logic               rstn = 1'b0;
	wire                sclk;
	wire                csN;
	wire                din;
	logic [WIPER_W-1:0] wA;
	logic [WIPER_W-1:0] wB;
	logic [255:0]       tA;
	logic [255:0]       tB;
	logic               cD;
	logic               fD;
	logic [7:0]         expA = RESET_CODE;
	logic [7:0]         expB = RESET_CODE;
	int                 mismatches = 0;
	int                 cmp_count = 0;
	int                 cycles = 0;
	integer             seed = 32'hd32bd96f;
	logic [8:0]         corners [4] = '{9'h000, 9'h1ff, 9'h0ff, 9'h100};

	dwsl_host host (.sclk(sclk), .csN(csN), .din(din));

	dwsl_top #(.TAPS(TAP_COUNT)) DUT (
		.mclk(mclk), .rstn(rstn), .sclk(sclk), .csN(csN), .din(din),
		.wiperPositionA(wA), .wiperPositionB(wB), .tapSelectA(tA), .tapSelectB(tB),
		.commitDone(cD), .frameDropped(fD)
	);

	// system clock, 4 ns
	always #2 mclk = ~mclk;

	// hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// one-hot tap expected for a code
	function automatic logic [255:0] tapOf(input logic [7:0] c);
		return 256'h1 << c;
	endfunction

	task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic checkAll();
		check("wiperPositionA", 256'(wA), 256'(expA));
		check("wiperPositionB", 256'(wB), 256'(expB));
		check("tapSelectA", tA, tapOf(expA));
		check("tapSelectB", tB, tapOf(expB));
	endtask

	// reset with the serial clock running so both domains clear
	task automatic doReset();
		rstn = 1'b0;
		fork
			host.pulse(6);
			repeat (8) @(posedge mclk);
		join
		@(posedge mclk);
		#1 rstn = 1'b1;
		// link-side reset lets go only on sclk edges, so clock a few with select high
		host.pulse(3);
		expA = RESET_CODE;
		expB = RESET_CODE;
		repeat (6) @(posedge mclk);
		#1;
		checkAll();
		check("commitDone", 256'(cD), 256'h0);
		check("frameDropped", 256'(fD), 256'h0);
	endtask

	// send a frame, wait for its outcome pulse, compare
	task automatic frame(input logic [15:0] bits, input int n, input logic expC);
		logic gotC;
		logic gotD;
		gotC = 1'b0;
		gotD = 1'b0;
		host.send(bits, n);
		for (int i = 0; i < 14 && !gotC && !gotD; i++) begin
			@(posedge mclk);
			#1;
			gotC = (cD === 1'b1);
			gotD = (fD === 1'b1);
		end
		if (expC && bits[8] === SEL_B)
			expB = bits[7:0];
		else if (expC)
			expA = bits[7:0];
		check("commitDone", 256'(gotC), 256'(expC));
		check("frameDropped", 256'(gotD), 256'(!expC));
		checkAll();
		repeat (30) @(posedge mclk);
		#1;
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// main sequence
	initial begin
		doReset();
		$display("test reset done");
		foreach (corners[i])
			frame(16'(corners[i]), 9, 1'b1);
		$display("test corners done");
		frame(16'h5d3c, 16, 1'b1);
		repeat (20)
			frame(16'($random(seed)), 9 + ($random(seed) & 7), 1'b1);
		$display("test random done");
		frame(16'h01ff, 8, 1'b0);
		frame(16'h0001, 1, 1'b0);
		$display("test short done");
		host.pulse(12);
		repeat (12) @(posedge mclk);
		#1;
		check("commitDone", 256'(cD), 256'h0);
		checkAll();
		$display("test idle clocks done");
		// deselected clocks while the frame is still being committed
		fork
			frame(16'h0155, 9, 1'b1);
			begin
				wait (csN === 1'b0);
				wait (csN === 1'b1);
				#1 host.pulse(4);
			end
		join
		doReset();
		frame(16'h00c3, 9, 1'b1);
		$display("test second reset done");
		report_and_stop();
	end
endmodule
